// *** design/ibsc_pkg.sv ***
// shared constants and types for the boot strap configuration block
package ibsc_pkg;
	localparam int IBSC_STABLE_CYCLES = 10;
	localparam int IBSC_SCL_MAX_KHZ = 100;
	localparam int IBSC_CLK_MHZ = 25;
	localparam int IBSC_SCL_HALF_CYCLES = (IBSC_CLK_MHZ * 1000 + 2 * IBSC_SCL_MAX_KHZ - 1) / (2 * IBSC_SCL_MAX_KHZ);
	localparam logic [4:0] IBSC_SLAVE_ADDR_HIGH_RST = 5'h1a;
	localparam logic [4:0] IBSC_EEPROM_ADDR_HIGH_RST = 5'h14;
	localparam logic [1:0] IBSC_EEPROM_LOW_DEFAULT = 2'h0;
	localparam logic [3:0] IBSC_CNT_RST = 4'h0;
	typedef struct packed {
		logic load_disable;
		logic multibyte_addr_strap;
		logic eeprom_sel;
		logic [1:0] slave_addr_low_straps;
	} ibsc_straps_t;
endpackage

// *** design/ibsc_scl_gen.sv ***
// serial clock divider for the boot loader, bounded to the maximum bus rate
`timescale 1ns/10ps
module ibsc_scl_gen
	import ibsc_pkg::*;
#(
	parameter int HALF_CYCLES = IBSC_SCL_HALF_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic run,
	output logic scl_low,
	output logic tick
);
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic next_scl_low;
	logic next_tick;
	always_comb begin
		next_cnt = cnt;
		next_scl_low = scl_low;
		next_tick = 1'b0;
		if (!run) begin
			next_cnt = 16'h0000;
			next_scl_low = 1'b0;
		end else if (cnt == 16'(HALF_CYCLES - 1)) begin
			next_cnt = 16'h0000;
			next_scl_low = !scl_low;
			next_tick = 1'b1;
		end else begin
			next_cnt = cnt + 16'h0001;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt <= 16'h0000;
			scl_low <= 1'b0;
			tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			scl_low <= next_scl_low;
			tick <= next_tick;
		end
	end
	int half_len;
	always_ff @(posedge sys_clk) begin
		if (rst || !run || tick) begin
			half_len <= 0;
		end else begin
			half_len <= half_len + 1;
		end
	end
	// a tick may never come sooner than one full half period after the last one or the start
	property p_scl_half;
		@(posedge sys_clk) disable iff (rst) tick |-> half_len >= HALF_CYCLES - 1;
	endproperty
	a_scl_half: assert property (p_scl_half) else $error("serial clock half period too short");
endmodule

// *** design/ibsc_boot_strap.sv ***
// boot strap capture, address formation and boot load sequencing
`timescale 1ns/10ps
module ibsc_boot_strap
	import ibsc_pkg::*;
#(
	parameter int STABLE_CYCLES = IBSC_STABLE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic hardware_reset_n,
	input wire logic load_disable_strap,
	input wire logic multibyte_addr_strap,
	input wire logic eeprom_sel_strap,
	input wire logic [1:0] slave_addr_low_straps,
	input wire logic sw_slave_low_we,
	input wire logic [1:0] sw_slave_low,
	input wire logic sw_eeprom_low_we,
	input wire logic [1:0] sw_eeprom_low,
	input wire logic load_done,
	output logic straps_latched,
	output logic load_busy,
	output logic load_start,
	output logic multibyte_mode,
	output logic slave_if_enable,
	output logic [6:0] slave_addr,
	output logic [6:0] eeprom_addr,
	output logic boot_scl_low,
	output logic boot_scl_tick
);
	////////////////////////////////////////////////////////////////
	// reset: the pin acts at once, release is synchronised
	logic rst_meta_n;
	logic rst_sync_n;
	logic int_rst;
	always_ff @(posedge sys_clk or negedge hardware_reset_n) begin
		if (!hardware_reset_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end
	assign int_rst = rst || !rst_sync_n;
	////////////////////////////////////////////////////////////////
	// strap synchronisers
	ibsc_straps_t pin_meta;
	ibsc_straps_t pin_sync;
	always_ff @(posedge sys_clk) begin
		pin_meta <= '{load_disable_strap, multibyte_addr_strap, eeprom_sel_strap, slave_addr_low_straps};
		pin_sync <= pin_meta;
	end
	////////////////////////////////////////////////////////////////
	// stability window and one-time latch
	logic [3:0] win_cnt;
	logic [3:0] next_win_cnt;
	logic latched;
	logic next_latched;
	ibsc_straps_t straps;
	ibsc_straps_t next_straps;
	always_comb begin
		next_win_cnt = win_cnt;
		next_latched = latched;
		next_straps = straps;
		if (!latched) begin
			// sample late in the window so the synchroniser delay stays inside it
			if (win_cnt == 4'(STABLE_CYCLES - 1)) begin
				next_latched = 1'b1;
				next_straps = pin_sync;
			end else begin
				next_win_cnt = win_cnt + 4'h1;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (int_rst) begin
			win_cnt <= IBSC_CNT_RST;
			latched <= 1'b0;
			straps <= '0;
		end else begin
			win_cnt <= next_win_cnt;
			latched <= next_latched;
			straps <= next_straps;
		end
	end
	assign straps_latched = latched;
	assign multibyte_mode = straps.multibyte_addr_strap;
	assign slave_if_enable = latched;
	////////////////////////////////////////////////////////////////
	// address low bits, software overrides after latch
	logic [1:0] slave_low;
	logic [1:0] next_slave_low;
	logic [1:0] eeprom_low;
	logic [1:0] next_eeprom_low;
	always_comb begin
		next_slave_low = slave_low;
		next_eeprom_low = eeprom_low;
		if (!latched) begin
			next_slave_low = pin_sync.slave_addr_low_straps;
			next_eeprom_low = pin_sync.eeprom_sel ? pin_sync.slave_addr_low_straps
				: IBSC_EEPROM_LOW_DEFAULT;
		end else begin
			if (sw_slave_low_we) begin
				next_slave_low = sw_slave_low;
			end
			if (sw_eeprom_low_we) begin
				next_eeprom_low = sw_eeprom_low;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (int_rst) begin
			slave_low <= 2'h0;
			eeprom_low <= IBSC_EEPROM_LOW_DEFAULT;
		end else begin
			slave_low <= next_slave_low;
			eeprom_low <= next_eeprom_low;
		end
	end
	assign slave_addr = {IBSC_SLAVE_ADDR_HIGH_RST, slave_low};
	assign eeprom_addr = {IBSC_EEPROM_ADDR_HIGH_RST, eeprom_low};
	////////////////////////////////////////////////////////////////
	// boot load sequencing
	typedef enum logic [1:0] {IBSC_WAIT, IBSC_START, IBSC_LOAD, IBSC_DONE} ibsc_state_t;
	ibsc_state_t state;
	ibsc_state_t next_state;
	always_comb begin
		next_state = state;
		unique case (state)
			IBSC_WAIT: begin
				if (latched) begin
					next_state = straps.load_disable ? IBSC_DONE : IBSC_START;
				end
			end
			IBSC_START: begin
				next_state = IBSC_LOAD;
			end
			IBSC_LOAD: begin
				if (load_done) begin
					next_state = IBSC_DONE;
				end
			end
			IBSC_DONE: begin
				next_state = IBSC_DONE;
			end
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (int_rst) begin
			state <= IBSC_WAIT;
		end else begin
			state <= next_state;
		end
	end
	assign load_start = (state == IBSC_START);
	assign load_busy = (state == IBSC_START) || (state == IBSC_LOAD);
	ibsc_scl_gen u_scl (
		.sys_clk(sys_clk),
		.rst(int_rst),
		.run(state == IBSC_LOAD),
		.scl_low(boot_scl_low),
		.tick(boot_scl_tick)
	);
	////////////////////////////////////////////////////////////////
	// checks
	property p_latch_time;
		@(posedge sys_clk) disable iff (int_rst) $rose(latched) |-> win_cnt == 4'(STABLE_CYCLES - 1);
	endproperty
	a_latch_time: assert property (p_latch_time) else $error("straps latched at wrong time");
	property p_straps_hold;
		@(posedge sys_clk) disable iff (int_rst) latched |=> $stable(straps);
	endproperty
	a_straps_hold: assert property (p_straps_hold) else $error("latched straps changed");
	property p_skip_load;
		@(posedge sys_clk) disable iff (int_rst) $rose(latched) && straps.load_disable |-> ##1 !load_busy [*4];
	endproperty
	a_skip_load: assert property (p_skip_load) else $error("load ran while disabled");
	property p_do_load;
		@(posedge sys_clk) disable iff (int_rst) $rose(latched) && !straps.load_disable |-> ##1 load_start;
	endproperty
	a_do_load: assert property (p_do_load) else $error("load did not start");
	property p_start_after_latch;
		@(posedge sys_clk) disable iff (int_rst) load_start |-> latched && !straps.load_disable;
	endproperty
	a_start_after_latch: assert property (p_start_after_latch) else $error("load started early");
	property p_eeprom_default;
		@(posedge sys_clk) disable iff (int_rst) $rose(latched) && !straps.eeprom_sel |-> eeprom_low == 2'h0;
	endproperty
	a_eeprom_default: assert property (p_eeprom_default) else $error("eeprom low bits not zero");
	property p_eeprom_sel;
		@(posedge sys_clk) disable iff (int_rst) $rose(latched) && straps.eeprom_sel
			|-> eeprom_low == straps.slave_addr_low_straps;
	endproperty
	a_eeprom_sel: assert property (p_eeprom_sel) else $error("eeprom low bits not from straps");
	property p_slave_from_pins;
		@(posedge sys_clk) disable iff (int_rst) $rose(latched) |-> slave_low == straps.slave_addr_low_straps;
	endproperty
	a_slave_from_pins: assert property (p_slave_from_pins) else $error("slave low bits not from straps");
	property p_sw_slave;
		@(posedge sys_clk) disable iff (int_rst) latched && sw_slave_low_we |=> slave_addr[1:0] == $past(sw_slave_low);
	endproperty
	a_sw_slave: assert property (p_sw_slave) else $error("slave override lost");
	property p_sw_eeprom;
		@(posedge sys_clk) disable iff (int_rst) latched && sw_eeprom_low_we |=> eeprom_addr[1:0] == $past(sw_eeprom_low);
	endproperty
	a_sw_eeprom: assert property (p_sw_eeprom) else $error("eeprom override lost");
	// the mode must be the synchronised pin value taken at the latch edge
	property p_mode;
		@(posedge sys_clk) disable iff (int_rst) $rose(latched) |-> multibyte_mode == $past(pin_sync.multibyte_addr_strap);
	endproperty
	a_mode: assert property (p_mode) else $error("addressing mode mismatch");
	property p_slave_on;
		@(posedge sys_clk) disable iff (int_rst) latched |-> slave_if_enable;
	endproperty
	a_slave_on: assert property (p_slave_on) else $error("slave access blocked");
	c_load: cover property (@(posedge sys_clk) disable iff (int_rst) load_start ##[1:1000] load_done);
	c_skip: cover property (@(posedge sys_clk) disable iff (int_rst) $rose(latched) && straps.load_disable);
	c_sw: cover property (@(posedge sys_clk) disable iff (int_rst) latched && sw_eeprom_low_we);
endmodule

// *** tb/ibsc_eeprom_model.sv ***
// behavioural boot eeprom load engine that answers the boot load handshake
`timescale 1ns/10ps
module ibsc_eeprom_model
	import ibsc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic load_start,
	input wire logic [15:0] hold_cycles,
	output logic load_done
);
	logic active = 1'b0;
	logic [15:0] cnt = 16'h0000;
	initial load_done = 1'b0;
	// done only ever follows a start, after a hold that the bench varies
	always @(posedge sys_clk) begin
		load_done <= 1'b0;
		cnt <= cnt + 16'h0001;
		if (rst) begin
			active <= 1'b0;
		end else if (load_start === 1'b1) begin
			active <= 1'b1;
			cnt <= 16'h0000;
		end else if (active && cnt >= hold_cycles) begin
			active <= 1'b0;
			load_done <= 1'b1;
		end
	end
endmodule

// *** tb/ibsc_boot_strap_test.sv ***
// self-checking bench for strap capture, address forming and boot load
`timescale 1ns/10ps
module ibsc_boot_strap_test
	import ibsc_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic hardware_reset_n = 1'b1;
	ibsc_straps_t st = '0;
	logic sw_slave_low_we = 1'b0;
	logic [1:0] sw_slave_low = 2'h0;
	logic sw_eeprom_low_we = 1'b0;
	logic [1:0] sw_eeprom_low = 2'h0;
	logic [15:0] hold = 16'h012c;
	logic load_done, straps_latched, load_busy, load_start, multibyte_mode, slave_if_enable;
	logic boot_scl_low, boot_scl_tick, wr_seen, was;
	logic scl_prev = 1'b0;
	logic tap_src_n = 1'b1;
	logic test_rst_n;
	logic have_prev = 1'b0;
	logic [6:0] slave_addr, eeprom_addr;
	logic [14:0] exp_q[$];
	logic [14:0] note;
	logic [1:0] sl, el;
	int error_cnt = 0, check_count = 0, starts = 0, ticks = 0, gap = 0, k;

	always #20 sys_clk = ~sys_clk;

	// board side: test reset is the and of hard reset and its own source
	assign test_rst_n = hardware_reset_n & tap_src_n;

	ibsc_boot_strap uut (
		.sys_clk(sys_clk),
		.rst(rst),
		.hardware_reset_n(hardware_reset_n),
		.load_disable_strap(st.load_disable),
		.multibyte_addr_strap(st.multibyte_addr_strap),
		.eeprom_sel_strap(st.eeprom_sel),
		.slave_addr_low_straps(st.slave_addr_low_straps),
		.sw_slave_low_we(sw_slave_low_we),
		.sw_slave_low(sw_slave_low),
		.sw_eeprom_low_we(sw_eeprom_low_we),
		.sw_eeprom_low(sw_eeprom_low),
		.load_done(load_done),
		.straps_latched(straps_latched),
		.load_busy(load_busy),
		.load_start(load_start),
		.multibyte_mode(multibyte_mode),
		.slave_if_enable(slave_if_enable),
		.slave_addr(slave_addr),
		.eeprom_addr(eeprom_addr),
		.boot_scl_low(boot_scl_low),
		.boot_scl_tick(boot_scl_tick)
	);

	ibsc_eeprom_model eeprom (
		.sys_clk(sys_clk),
		.rst(rst | ~hardware_reset_n),
		.load_start(load_start),
		.hold_cycles(hold),
		.load_done(load_done)
	);

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (e !== g) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// result watcher: a latch or an accepted write consumes one note
	always @(posedge sys_clk) begin
		wr_seen = straps_latched && (sw_slave_low_we || sw_eeprom_low_we);
		was = straps_latched;
		#1;
		if (wr_seen || (straps_latched === 1'b1 && !was)) begin
			note = (exp_q.size() > 0) ? exp_q.pop_front() : 15'h7fff;
			chk("config", 16'(note), 16'({multibyte_mode, slave_addr, eeprom_addr}));
		end
	end

	// half periods are measured only between ticks of one load
	always @(posedge sys_clk) begin
		gap++;
		if (load_start === 1'b1) starts++;
		// the last tick of a load can land in the same cycle that busy drops, so check before clearing
		if (boot_scl_tick === 1'b1) begin
			if (have_prev) chk("scl_gap", 16'h1, 16'(gap >= IBSC_SCL_HALF_CYCLES));
			chk("scl_level", 16'(!scl_prev), 16'(boot_scl_low));
			scl_prev = boot_scl_low;
			have_prev = 1'b1;
			gap = 0;
			ticks++;
		end
		if (load_busy !== 1'b1) begin
			have_prev = 1'b0;
			scl_prev = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h63b7a3d0));
		for (int it = 0; it < 8; it++) begin
			@(negedge sys_clk);
			st = 5'($urandom);
			st.load_disable = it[0];
			st.eeprom_sel = it[1];
			hold = 16'($urandom_range(300, 700));
			tap_src_n = 1'($urandom);
			if (it[2]) hardware_reset_n = 1'b0;
			else rst = 1'b1;
			repeat (3) @(negedge sys_clk);
			chk("reset_state", 16'h0, 16'({straps_latched, load_busy, load_start}));
			if (it[2]) chk("test_rst", 16'h0, 16'(test_rst_n));
			rst = 1'b0;
			hardware_reset_n = 1'b1;
			sl = st.slave_addr_low_straps;
			el = st.eeprom_sel ? sl : IBSC_EEPROM_LOW_DEFAULT;
			exp_q.push_back({st.multibyte_addr_strap, IBSC_SLAVE_ADDR_HIGH_RST, sl, IBSC_EEPROM_ADDR_HIGH_RST, el});
			starts = 0;
			ticks = 0;
			@(negedge sys_clk);
			// writes inside the window must be dropped, straps win
			sw_slave_low_we = 1'b1;
			sw_slave_low = ~sl;
			sw_eeprom_low_we = 1'b1;
			sw_eeprom_low = ~el;
			@(negedge sys_clk);
			sw_slave_low_we = 1'b0;
			sw_eeprom_low_we = 1'b0;
			for (k = 2; k < 20 && straps_latched !== 1'b1; k++) @(negedge sys_clk);
			chk("latch_delay", 16'h1, 16'(k >= IBSC_STABLE_CYCLES && k <= IBSC_STABLE_CYCLES + 3));
			repeat (3) @(negedge sys_clk);
			chk("starts", 16'(!st.load_disable), 16'(starts));
			chk("slave_if", 16'h1, 16'(slave_if_enable));
			for (k = 0; k < 2000 && load_busy === 1'b1; k++) @(negedge sys_clk);
			chk("busy_end", 16'h0, 16'(load_busy));
			chk("ticks_seen", 16'(!st.load_disable), 16'(ticks > 1));
			st = ~st;
			for (k = 0; k < 3; k++) begin
				@(negedge sys_clk);
				sw_slave_low_we = 1'($urandom);
				sw_eeprom_low_we = (k == 1) | 1'($urandom);
				sw_slave_low = 2'($urandom);
				sw_eeprom_low = 2'($urandom);
				if (sw_slave_low_we) sl = sw_slave_low;
				if (sw_eeprom_low_we) el = sw_eeprom_low;
				// after the latch the watcher pops only on an accepted write, so only a write leaves a note
				if (sw_slave_low_we || sw_eeprom_low_we) begin
					exp_q.push_back({~st.multibyte_addr_strap, IBSC_SLAVE_ADDR_HIGH_RST, sl, IBSC_EEPROM_ADDR_HIGH_RST, el});
				end
			end
			@(negedge sys_clk);
			sw_slave_low_we = 1'b0;
			sw_eeprom_low_we = 1'b0;
			repeat (3) @(negedge sys_clk);
			chk("held", 16'({1'b1, ~st.multibyte_addr_strap}), 16'({straps_latched, multibyte_mode}));
			chk("notes_left", 16'h0, 16'(exp_q.size()));
		end
		summarize();
	end

	// eight passes need well under ten thousand cycles
	initial begin
		#(40 * 30000);
		error_cnt++;
		summarize();
	end
endmodule
